// File: design/msr_defines.svh
`ifndef MSR_DEFINES_SVH
`define MSR_DEFINES_SVH

// Register indices within the 32-entry management space
`define MSR_REG_CTRL 5'h00
`define MSR_REG_STATUS 5'h01
`define MSR_REG_IDENT_HIGH 5'h02
`define MSR_REG_IDENT_LOW 5'h03
`define MSR_REG_EXT_STATUS 5'h0f

// Control register bit positions; only reset, loopback and power-down are live
`define MSR_CTRL_RESET_BIT 15
`define MSR_CTRL_LOOPBACK_BIT 14
`define MSR_CTRL_SPEED_LSB_BIT 13
`define MSR_CTRL_AUTONEG_BIT 12
`define MSR_CTRL_POWER_DOWN_BIT 11
`define MSR_CTRL_ISOLATE_BIT 10
`define MSR_CTRL_RESTART_BIT 9
`define MSR_CTRL_DUPLEX_BIT 8
`define MSR_CTRL_COLLISION_BIT 7
`define MSR_CTRL_SPEED_MSB_BIT 6

// Reset and constant read values
`define MSR_CTRL_RESET_VALUE 16'h0140
`define MSR_CTRL_FIXED_ONES 16'h0140
`define MSR_CTRL_RSVD_MASK 16'h003f
`define MSR_STATUS_VALUE 16'h0101
`define MSR_EXT_STATUS_VALUE 16'h0000
`define MSR_UNMAPPED_VALUE 16'h0000

// Serial frame timing in management clock periods, opcodes, and synchroniser width in bits
`define MSR_PREAMBLE_LEN 6'd32
`define MSR_OP_READ 2'b10
`define MSR_OP_WRITE 2'b01
`define MSR_ADDR_LAST 6'd4
`define MSR_DATA_LAST 6'd15
`define MSR_SYNC_WIDTH 9

`endif

// File: design/msr_pkg.sv
package msr_pkg;

    typedef logic [7:0] msr_chan_t;

    typedef enum logic [2:0] {
        FR_PREAMBLE,
        FR_START,
        FR_OPCODE,
        FR_PHY_ADDR,
        FR_REG_ADDR,
        FR_TURN,
        FR_DATA
    } msr_frame_t;

    // Pins after synchronisation
    typedef struct packed {
        logic mdc;
        logic mdio;
        logic reset_pin;
        logic loopback_pin;
        logic [4:0] phy_addr;
    } msr_pins_t;

    typedef struct packed {
        msr_frame_t fsm;
        logic [5:0] cnt;
        logic is_read;
        logic addr_hit;
        logic [4:0] phy;
        logic [4:0] reg_a;
        logic [15:0] shift;
        logic mdio_o;
        logic mdio_oe_n;
        logic mdc_prev;
        logic ctl_reset;
        logic ctl_loopback;
        logic ctl_power_down;
        logic wr_done;
    } msr_state_t;

endpackage

// File: design/msr_sync.sv
`timescale 1ns/1ps
module msr_sync #(
    parameter int W = 1
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } msr_sync_state_t;

    msr_sync_state_t st_q;
    msr_sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (i_ce) begin
            st_d.meta = i_async;
            st_d.stable = st_q.meta;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_sync = st_q.stable;
endmodule

// File: design/msr_regs.sv
`timescale 1ns/1ps
`include "msr_defines.svh"
module msr_regs #(
    // Unique identifier bits 3..24, bit 3 in the msb; value is arbitrary
    parameter logic [21:0] P_ORG_UNIQUE_IDENTIFIER = 22'h2a5c31,
    // Model number; value is arbitrary
    parameter logic [5:0] P_MODEL = 6'h15,
    // Revision number; value is arbitrary
    parameter logic [3:0] P_REVISION = 4'h3
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe_n,
    input wire logic [4:0] i_phy_addr,
    input wire logic i_reset_pin,
    input wire logic i_loopback_pin,
    output logic o_global_reset,
    output msr_pkg::msr_chan_t o_chan_loopback,
    output logic o_power_down
);
    import msr_pkg::*;

    localparam msr_state_t ST_RESET = '{
        fsm: FR_PREAMBLE,
        cnt: 6'h00,
        is_read: 1'b0,
        addr_hit: 1'b0,
        phy: 5'h00,
        reg_a: 5'h00,
        shift: 16'h0000,
        mdio_o: 1'b0,
        mdio_oe_n: 1'b1,
        mdc_prev: 1'b0,
        ctl_reset: 1'b0,
        ctl_loopback: 1'b0,
        ctl_power_down: 1'b0,
        wr_done: 1'b0
    };

    msr_state_t st_q;
    msr_state_t st_d;
    msr_pins_t pins_s;
    logic mdc_rise;
    logic [15:0] wdata;
    logic [4:0] next_addr;

    msr_sync #(
        .W(`MSR_SYNC_WIDTH)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_async({i_mdc, i_mdio, i_reset_pin, i_loopback_pin, i_phy_addr}),
        .o_sync(pins_s)
    );

    assign mdc_rise = pins_s.mdc && !st_q.mdc_prev;
    assign wdata = {st_q.shift[14:0], pins_s.mdio};
    assign next_addr = {st_q.reg_a[3:0], pins_s.mdio};

    function automatic logic [15:0] read_value(input logic [4:0] addr, input msr_state_t s);
        logic [15:0] v;
        v = `MSR_UNMAPPED_VALUE;
        case (addr)
            `MSR_REG_CTRL: begin
                // Fixed ones for duplex and speed msb, everything else not live is zero
                v = `MSR_CTRL_FIXED_ONES;
                v[`MSR_CTRL_RESET_BIT] = s.ctl_reset;
                v[`MSR_CTRL_LOOPBACK_BIT] = s.ctl_loopback;
                v[`MSR_CTRL_POWER_DOWN_BIT] = s.ctl_power_down;
            end
            `MSR_REG_STATUS: v = `MSR_STATUS_VALUE;
            `MSR_REG_IDENT_HIGH: v = P_ORG_UNIQUE_IDENTIFIER[21:6];
            `MSR_REG_IDENT_LOW: v = {P_ORG_UNIQUE_IDENTIFIER[5:0], P_MODEL, P_REVISION};
            `MSR_REG_EXT_STATUS: v = `MSR_EXT_STATUS_VALUE;
            default: v = `MSR_UNMAPPED_VALUE;
        endcase
        return v;
    endfunction

    // Frames are decoded on rising edges of the synchronised management clock
    always_comb begin
        st_d = st_q;
        if (i_ce) begin
            st_d.wr_done = 1'b0;
            st_d.mdc_prev = pins_s.mdc;
            if (mdc_rise) begin
                if (st_q.ctl_reset) begin
                    st_d.ctl_reset = 1'b0;
                end
                case (st_q.fsm)
                    FR_PREAMBLE: begin
                        if (pins_s.mdio) begin
                            if (st_q.cnt != `MSR_PREAMBLE_LEN) begin
                                st_d.cnt = st_q.cnt + 6'd1;
                            end
                        end else if (st_q.cnt == `MSR_PREAMBLE_LEN) begin
                            st_d.fsm = FR_START;
                            st_d.cnt = 6'd0;
                        end else begin
                            st_d.cnt = 6'd0;
                        end
                    end
                    FR_START: begin
                        st_d.cnt = 6'd0;
                        st_d.fsm = pins_s.mdio ? FR_OPCODE : FR_PREAMBLE;
                    end
                    FR_OPCODE: begin
                        st_d.shift = wdata;
                        if (st_q.cnt == 6'd0) begin
                            st_d.cnt = 6'd1;
                        end else begin
                            st_d.cnt = 6'd0;
                            st_d.is_read = (wdata[1:0] == `MSR_OP_READ);
                            if (wdata[1:0] == `MSR_OP_READ || wdata[1:0] == `MSR_OP_WRITE) begin
                                st_d.fsm = FR_PHY_ADDR;
                            end else begin
                                st_d.fsm = FR_PREAMBLE;
                            end
                        end
                    end
                    FR_PHY_ADDR: begin
                        st_d.phy = {st_q.phy[3:0], pins_s.mdio};
                        if (st_q.cnt == `MSR_ADDR_LAST) begin
                            st_d.addr_hit = ({st_q.phy[3:0], pins_s.mdio} == pins_s.phy_addr);
                            st_d.fsm = FR_REG_ADDR;
                            st_d.cnt = 6'd0;
                        end else begin
                            st_d.cnt = st_q.cnt + 6'd1;
                        end
                    end
                    FR_REG_ADDR: begin
                        st_d.reg_a = next_addr;
                        if (st_q.cnt == `MSR_ADDR_LAST) begin
                            st_d.shift = read_value(next_addr, st_q);
                            st_d.fsm = FR_TURN;
                            st_d.cnt = 6'd0;
                        end else begin
                            st_d.cnt = st_q.cnt + 6'd1;
                        end
                    end
                    FR_TURN: begin
                        // First turnaround bit stays released, the zero goes out for the second
                        if (st_q.cnt == 6'd0) begin
                            st_d.cnt = 6'd1;
                            if (st_q.is_read && st_q.addr_hit) begin
                                st_d.mdio_oe_n = 1'b0;
                                st_d.mdio_o = 1'b0;
                            end
                        end else begin
                            st_d.fsm = FR_DATA;
                            st_d.cnt = 6'd0;
                            if (st_q.is_read && st_q.addr_hit) begin
                                st_d.mdio_o = st_q.shift[15];
                                st_d.shift = {st_q.shift[14:0], 1'b0};
                            end
                        end
                    end
                    FR_DATA: begin
                        if (st_q.is_read) begin
                            if (st_q.cnt == `MSR_DATA_LAST) begin
                                st_d.mdio_oe_n = 1'b1;
                                st_d.mdio_o = 1'b0;
                                st_d.fsm = FR_PREAMBLE;
                                st_d.cnt = 6'd0;
                            end else begin
                                if (st_q.addr_hit) begin
                                    st_d.mdio_o = st_q.shift[15];
                                end
                                st_d.shift = {st_q.shift[14:0], 1'b0};
                                st_d.cnt = st_q.cnt + 6'd1;
                            end
                        end else begin
                            st_d.shift = wdata;
                            if (st_q.cnt == `MSR_DATA_LAST) begin
                                st_d.fsm = FR_PREAMBLE;
                                st_d.cnt = 6'd0;
                                st_d.wr_done = st_q.addr_hit;
                                // Only three control bits are writable; all else is dropped
                                if (st_q.addr_hit && st_q.reg_a == `MSR_REG_CTRL) begin
                                    st_d.ctl_reset = wdata[`MSR_CTRL_RESET_BIT];
                                    st_d.ctl_loopback = wdata[`MSR_CTRL_LOOPBACK_BIT];
                                    st_d.ctl_power_down = wdata[`MSR_CTRL_POWER_DOWN_BIT];
                                end
                            end else begin
                                st_d.cnt = st_q.cnt + 6'd1;
                            end
                        end
                    end
                    default: begin
                        st_d.fsm = FR_PREAMBLE;
                        st_d.cnt = 6'd0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_mdio = st_q.mdio_o;
    assign o_mdio_oe_n = st_q.mdio_oe_n;
    // Soft reset does not clear these registers, so the serial port stays usable
    assign o_global_reset = st_q.ctl_reset | pins_s.reset_pin;
    assign o_chan_loopback = {8{st_q.ctl_loopback | pins_s.loopback_pin}};
    // Power-down never gates the frame logic above
    assign o_power_down = st_q.ctl_power_down;

    // Checks
    logic ld_rd;
    logic wr_ctrl;
    assign ld_rd = i_ce && mdc_rise && st_q.fsm == FR_REG_ADDR && st_q.cnt == `MSR_ADDR_LAST;
    assign wr_ctrl = i_ce && mdc_rise && st_q.fsm == FR_DATA && !st_q.is_read
        && st_q.cnt == `MSR_DATA_LAST && st_q.addr_hit && st_q.reg_a == `MSR_REG_CTRL;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_soft_set;
        wr_ctrl && wdata[`MSR_CTRL_RESET_BIT];
    endsequence
    sequence s_pd_clear;
        wr_ctrl && !wdata[`MSR_CTRL_POWER_DOWN_BIT] && st_q.ctl_power_down;
    endsequence
    sequence s_read_turn;
        i_ce && mdc_rise && st_q.fsm == FR_TURN && st_q.cnt == 6'd0
            && st_q.is_read && st_q.addr_hit;
    endsequence

    soft_set_a: assert property (s_soft_set |=> o_global_reset && st_q.ctl_reset)
        else $error("Soft reset bit not set by write");
    soft_clear_a: assert property (i_ce && mdc_rise && st_q.ctl_reset |=> !st_q.ctl_reset)
        else $error("Soft reset bit did not self clear");
    reset_or_a: assert property (pins_s.reset_pin |-> o_global_reset)
        else $error("Reset pin not seen on global reset");
    reset_idle_a: assert property (!st_q.ctl_reset && !pins_s.reset_pin |-> !o_global_reset)
        else $error("Global reset without cause");
    loop_on_a: assert property (pins_s.loopback_pin |-> o_chan_loopback == 8'hff)
        else $error("Loopback pin did not loop all channels");
    loop_off_a: assert property (!st_q.ctl_loopback && !pins_s.loopback_pin
        |-> o_chan_loopback == 8'h00)
        else $error("Loopback active without cause");
    power_mdio_a: assert property (s_pd_clear |=> !o_power_down)
        else $error("Power down could not be cleared over serial port");
    ctrl_zero_a: assert property (ld_rd && next_addr == `MSR_REG_CTRL
        |=> st_q.shift[13:12] == 2'b00 && st_q.shift[10:9] == 2'b00 && !st_q.shift[7])
        else $error("Unsupported control bits read nonzero");
    duplex_one_a: assert property (ld_rd && next_addr == `MSR_REG_CTRL |=> st_q.shift[8])
        else $error("Duplex bit read zero");
    speed_msb_a: assert property (ld_rd && next_addr == `MSR_REG_CTRL |=> st_q.shift[6])
        else $error("Speed msb read zero");
    ctrl_rsvd_a: assert property (ld_rd && next_addr == `MSR_REG_CTRL
        |=> st_q.shift[5:0] == 6'h00)
        else $error("Reserved control bits read nonzero");
    status_word_a: assert property (ld_rd && next_addr == `MSR_REG_STATUS
        |=> st_q.shift == 16'h0101)
        else $error("Status word wrong");
    ident_high_a: assert property (ld_rd && next_addr == `MSR_REG_IDENT_HIGH
        |=> st_q.shift == P_ORG_UNIQUE_IDENTIFIER[21:6])
        else $error("First identifier word wrong");
    ident_low_a: assert property (ld_rd && next_addr == `MSR_REG_IDENT_LOW
        |=> st_q.shift[15:10] == P_ORG_UNIQUE_IDENTIFIER[5:0]
            && st_q.shift[9:4] == P_MODEL && st_q.shift[3:0] == P_REVISION)
        else $error("Second identifier word wrong");
    ext_status_a: assert property (ld_rd && next_addr == `MSR_REG_EXT_STATUS
        |=> st_q.shift == 16'h0000)
        else $error("Extended status nonzero");
    read_turn_a: assert property (s_read_turn |=> !o_mdio_oe_n && !o_mdio)
        else $error("Turnaround zero not driven");
    // Covers every address between the identifier words and extended status, and above it
    unmapped_zero_a: assert property (ld_rd && next_addr > `MSR_REG_IDENT_LOW
        && next_addr != `MSR_REG_EXT_STATUS |=> st_q.shift == 16'h0000)
        else $error("Unmapped register read nonzero");
endmodule

// File: tb/msr_station.sv
`timescale 1ns/1ps
module msr_station #(
    parameter int HALF = 5
) (
    input wire logic i_core_clk,
    input wire logic i_mdio,
    output logic o_mdc,
    output logic o_mdio,
    output logic o_mdio_en
);
    initial begin
        o_mdc = 1'b0;
        o_mdio = 1'b0;
        o_mdio_en = 1'b0;
    end

    // Data changes while the clock is low; the line is sampled just before each rise
    task automatic bit_cell(input logic drive, input logic val, output logic seen);
        @(posedge i_core_clk);
        #1;
        o_mdc = 1'b0;
        o_mdio_en = drive;
        o_mdio = val;
        repeat (HALF) @(posedge i_core_clk);
        #1;
        seen = i_mdio;
        o_mdc = 1'b1;
        repeat (HALF - 1) @(posedge i_core_clk);
    endtask

    // Full frame with its own preamble; the line is released for turnaround and data on reads
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rdata,
                         output logic ta_low);
        logic [63:0] bits;
        logic s;
        bits = {32'hffffffff, 2'b01, (rd ? 2'b10 : 2'b01), phy, ra, 2'b10, wd};
        rdata = 16'h0000;
        ta_low = 1'b1;
        for (int i = 63; i >= 0; i--) begin
            bit_cell(!(rd && i < 18), bits[i], s);
            if (i < 16) begin
                rdata[i] = s;
            end
            if (i == 16) begin
                ta_low = s;
            end
        end
        // Clock stands still between frames
        @(posedge i_core_clk);
        #1;
        o_mdc = 1'b0;
        o_mdio_en = 1'b0;
    endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    import msr_pkg::*;
    // Identity values handed to the design; all arbitrary
    localparam logic [21:0] ORG_ID = 22'h1b3e07;
    localparam logic [5:0] MODEL = 6'h2c;
    localparam logic [3:0] REV = 4'h9;
    localparam logic [4:0] MY_PHY = 5'h0b;
    logic i_core_clk, i_rst_n, reset_pin, loopback_pin, ce;
    logic sta_mdc, sta_mdio, sta_en, dut_mdio, dut_oe_n, line;
    logic global_reset, power_down, ta;
    msr_chan_t chan_loopback;
    logic [15:0] rd;
    int fail_count, comparisons;
    logic [4:0] addr_tab [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0f, 5'h04, 5'h0e, 5'h10, 5'h1f};
    logic [15:0] val_tab [9] = '{16'h0140, 16'h0101, ORG_ID[21:6], {ORG_ID[5:0], MODEL, REV},
                                 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // Pull-up holds the shared line high when neither side drives
    assign line = !dut_oe_n ? dut_mdio : (sta_en ? sta_mdio : 1'b1);

    msr_regs #(.P_ORG_UNIQUE_IDENTIFIER(ORG_ID), .P_MODEL(MODEL), .P_REVISION(REV)) i_dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_mdc(sta_mdc),
        .i_mdio(line), .o_mdio(dut_mdio), .o_mdio_oe_n(dut_oe_n), .i_phy_addr(MY_PHY),
        .i_reset_pin(reset_pin), .i_loopback_pin(loopback_pin),
        .o_global_reset(global_reset), .o_chan_loopback(chan_loopback),
        .o_power_down(power_down)
    );

    msr_station i_sta (
        .i_core_clk(i_core_clk), .i_mdio(line), .o_mdc(sta_mdc), .o_mdio(sta_mdio),
        .o_mdio_en(sta_en)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        i_sta.frame(1'b0, MY_PHY, ra, wd, rd, ta);
        cyc(4);
    endtask

    task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
        i_sta.frame(1'b1, MY_PHY, ra, 16'h0000, rd, ta);
        check({15'h0000, ta}, 16'h0000);
        check(rd, exp);
    endtask

    task automatic outs(input logic gr, input logic lb, input logic pd);
        check({15'h0000, global_reset}, {15'h0000, gr});
        check({8'h00, chan_loopback}, {8'h00, {8{lb}}});
        check({15'h0000, power_down}, {15'h0000, pd});
    endtask

    initial begin
        repeat (100000) @(posedge i_core_clk);
        fail_count++;
        close_out();
    end

    initial begin
        i_rst_n = 1'b0;
        reset_pin = 1'b0;
        loopback_pin = 1'b0;
        ce = 1'b1;
        fail_count = 0;
        comparisons = 0;
        cyc(5);
        check({15'h0000, dut_oe_n}, 16'h0001);
        outs(1'b0, 1'b0, 1'b0);
        cyc(5);
        i_rst_n = 1'b1;
        cyc(4);
        for (int i = 0; i < 9; i++) begin
            rd_chk(addr_tab[i], val_tab[i]);
        end
        $display("test reset_values done");
        // Ones into each read-only address in the table must leave each word unchanged
        for (int i = 1; i < 9; i++) begin
            wr(addr_tab[i], 16'hffff);
            rd_chk(addr_tab[i], val_tab[i]);
        end
        $display("test read_only done");
        wr(5'h00, 16'h7fff);
        outs(1'b0, 1'b1, 1'b1);
        rd_chk(5'h00, 16'h4940);
        wr(5'h00, 16'h0000);
        outs(1'b0, 1'b0, 1'b0);
        rd_chk(5'h00, 16'h0140);
        $display("test control_bits done");
        i_sta.frame(1'b0, MY_PHY, 5'h00, 16'h8000, rd, ta);
        cyc(3);
        outs(1'b1, 1'b0, 1'b0);
        i_sta.bit_cell(1'b0, 1'b1, ta);
        cyc(4);
        outs(1'b0, 1'b0, 1'b0);
        rd_chk(5'h00, 16'h0140);
        $display("test self_clear done");
        reset_pin = 1'b1;
        loopback_pin = 1'b1;
        cyc(4);
        outs(1'b1, 1'b1, 1'b0);
        reset_pin = 1'b0;
        loopback_pin = 1'b0;
        cyc(4);
        outs(1'b0, 1'b0, 1'b0);
        $display("test pins done");
        // A low clock enable must freeze the pin synchronisers as well
        ce = 1'b0;
        loopback_pin = 1'b1;
        cyc(4);
        outs(1'b0, 1'b0, 1'b0);
        ce = 1'b1;
        cyc(4);
        outs(1'b0, 1'b1, 1'b0);
        loopback_pin = 1'b0;
        cyc(4);
        outs(1'b0, 1'b0, 1'b0);
        $display("test clock_enable done");
        i_sta.frame(1'b0, MY_PHY ^ 5'h01, 5'h00, 16'h4800, rd, ta);
        cyc(4);
        outs(1'b0, 1'b0, 1'b0);
        i_sta.frame(1'b1, MY_PHY ^ 5'h01, 5'h01, 16'h0000, rd, ta);
        check(rd, 16'hffff);
        $display("test other_address done");
        wr(5'h00, 16'h4000);
        outs(1'b0, 1'b1, 1'b0);
        i_rst_n = 1'b0;
        cyc(2);
        i_rst_n = 1'b1;
        cyc(4);
        outs(1'b0, 1'b0, 1'b0);
        rd_chk(5'h00, 16'h0140);
        $display("test mid_reset done");
        close_out();
    end
endmodule
